// [logic/adc_ctrl_pkg.sv]
/*
  Shared constants for the converter output and power control block: pin level codes,
  fixed full-scale codes, pipeline taps, sync field positions and calibration counts.
  Assumes the analog pin level detectors deliver a two-bit low/high/mid code per three-level pin.
*/
package adc_ctrl_pkg;

  // Three-level pin codes; an open pin reads as mid-supply.
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_HIGH = 2'h1;
  localparam logic [1:0] PIN_MID = 2'h2;

  // Full-scale range codes. The default is the nominal range.
  localparam int RANGE_CODE_W = 9;
  localparam logic [8:0] RANGE_CODE_LOW = 9'h000;
  localparam logic [8:0] RANGE_CODE_HIGH = 9'h1ff;
  localparam logic [8:0] RANGE_CODE_DEFAULT = 9'h100;

  // Output latency in sample clock cycles.
  localparam int LAT_DIRECT = 13;
  localparam int LAT_DELAYED = 14;
  localparam int DIRECT_TAP = LAT_DIRECT - 1;
  localparam int DELAYED_TAP = LAT_DELAYED - 1;

  // Calibration timing in input clock cycles.
  localparam int CAL_DELAY_DEFAULT = 33554432;
  localparam int CAL_CYCLES_DEFAULT = 65536;

  // Field positions of the synchronised pin vector.
  localparam int SP_RANGE = 0;
  localparam int SP_EDGE = 2;
  localparam int SP_DES = 4;
  localparam int SP_QDOWN = 6;
  localparam int SP_PD = 8;
  localparam int SP_CAL = 9;
  localparam int SP_W = 10;

  // Field positions of the mode vector passed to the link domain.
  localparam int MD_DES = 0;
  localparam int MD_DDR = 1;
  localparam int MD_RISE = 2;
  localparam int MD_PSAVE = 3;
  localparam int MD_QDOWN = 4;
  localparam int MD_CAL = 5;
  localparam int MD_W = 6;

  // Reset values.
  localparam logic [5:0] MODE_RESET = 6'h00;
  localparam logic [7:0] BUS_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_POWER_WAIT,
    ST_DELAY,
    ST_CALIB,
    ST_RUN
  } cal_state_type;

endpackage

// [logic/adc_output_power_control.sv]
/*
  Control and output side of a dual 8-bit converter: pin mode decode, calibration and
  power-down sequencing on i_clock, and the sample pipeline, output demultiplexing and
  forwarded output clock on the sample clock.
  Assumes the converter cores deliver one code per sample clock cycle and that the
  receiver captures four parallel buses with the forwarded clock.
*/
// Behaviour
// - Mid range pin takes serial full-scale code.
// - Edge pin high: SDR, data on rise.
// - Edge pin low: SDR, data on fall.
// - Edge pin mid: DDR, quarter-rate clock.
// - Duty corrector on unless extended register disables in extended mode.
// - Interleave: cores sample opposite clock edges.
// - Interleave: four buses at half rate.
// - Group order second-delayed to first-direct.
// - Normal interleave uses first input only.
// - Interleave runs background phase trimming.
// - Direct buses 13 cycles, delayed 14.
// - Second buses 13.5 and 14.5 in interleave.
// - Pin DDR only in normal control mode.
// - Full power-down tristates data outputs.
// - Power-down pulls clock and overrange low.
// - Second power-down stops second channel only.
// - Power-down during calibration waits for finish.
// - Power-down at power-up defers calibration.
// - Calibration command ignored while powered down.
// - Calibration active high throughout calibration.
// - Calibration stops clocks, outputs invalid.
module adc_output_power_control #(
  parameter int CAL_DELAY_CYCLES = adc_ctrl_pkg::CAL_DELAY_DEFAULT,
  parameter int CAL_CYCLES = adc_ctrl_pkg::CAL_CYCLES_DEFAULT
) (
  // Clocks and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_sample_clock_in,
  // Control pins, asynchronous
  input wire logic [1:0] i_range_select_pin,
  input wire logic [1:0] i_output_edge_select,
  input wire logic [1:0] i_des_select_pin,
  input wire logic [1:0] i_second_channel_power_down,
  input wire logic i_full_power_down,
  input wire logic i_calibration_command,
  // Extended mode register contents, on i_clock
  input wire logic [8:0] i_ext_fullscale_code,
  input wire logic i_ext_duty_corrector_off,
  input wire logic i_ext_ddr_enable,
  input wire logic i_ext_edge_rising,
  input wire logic i_ext_des_enable,
  input wire logic i_ext_des_source_second,
  // Converter cores, on the sample clock
  input wire logic [7:0] i_core_first_code,
  input wire logic [7:0] i_core_second_code,
  input wire logic i_core_overrange,
  // Analog control outputs, on i_clock
  output logic [8:0] o_fullscale_code,
  output logic o_duty_corrector_enable,
  output logic o_calibration_active,
  output logic o_power_saving,
  output logic o_second_channel_down,
  output logic o_core_clock_run,
  output logic o_phase_trim_enable,
  output logic o_des_source_second,
  // Output link, on the sample clock
  output logic o_forwarded_output_clock,
  output logic o_overrange_output,
  output logic [7:0] o_first_channel_direct_bus,
  output logic [7:0] o_first_channel_delayed_bus,
  output logic [7:0] o_second_channel_direct_bus,
  output logic [7:0] o_second_channel_delayed_bus,
  output logic o_first_data_enable,
  output logic o_second_data_enable
);

  localparam int CNT_W = 32;

  if (CAL_DELAY_CYCLES < 1 || CAL_CYCLES < 1) begin : g_count_check
    $error("calibration counts must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control domain: pin synchronisation and mode decode

  logic [adc_ctrl_pkg::SP_W-1:0] pins_async;
  logic [adc_ctrl_pkg::SP_W-1:0] pins_s;
  logic [1:0] range_pin;
  logic [1:0] edge_pin;
  logic [1:0] des_pin;
  logic pd_pin;
  logic qdown_pin;
  logic cal_pin;
  logic cal_pin_prev_q;
  logic normal_mode;
  logic [adc_ctrl_pkg::MD_W-1:0] mode_q;

  assign pins_async = {i_calibration_command, i_full_power_down, i_second_channel_power_down,
                       i_des_select_pin, i_output_edge_select, i_range_select_pin};

  level_sync #(.WIDTH(adc_ctrl_pkg::SP_W)) u_pin_sync (
    .i_clock(i_clock),
    .i_level(pins_async),
    .o_level(pins_s)
  );

  assign range_pin = pins_s[adc_ctrl_pkg::SP_RANGE +: 2];
  assign edge_pin = pins_s[adc_ctrl_pkg::SP_EDGE +: 2];
  assign des_pin = pins_s[adc_ctrl_pkg::SP_DES +: 2];
  assign qdown_pin = pins_s[adc_ctrl_pkg::SP_QDOWN +: 2] != adc_ctrl_pkg::PIN_LOW;
  assign pd_pin = pins_s[adc_ctrl_pkg::SP_PD];
  assign cal_pin = pins_s[adc_ctrl_pkg::SP_CAL];
  assign normal_mode = range_pin != adc_ctrl_pkg::PIN_MID;

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      cal_pin_prev_q <= 1'b1;
    end else begin
      cal_pin_prev_q <= cal_pin;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_fullscale_code <= adc_ctrl_pkg::RANGE_CODE_DEFAULT;
    end else if (range_pin == adc_ctrl_pkg::PIN_HIGH) begin
      o_fullscale_code <= adc_ctrl_pkg::RANGE_CODE_HIGH;
    end else if (range_pin == adc_ctrl_pkg::PIN_LOW) begin
      o_fullscale_code <= adc_ctrl_pkg::RANGE_CODE_LOW;
    end else begin
      o_fullscale_code <= i_ext_fullscale_code;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_duty_corrector_enable <= 1'b1;
    end else begin
      o_duty_corrector_enable <= normal_mode || !i_ext_duty_corrector_off;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_des_source_second <= 1'b0;
    end else begin
      o_des_source_second <= !normal_mode && i_ext_des_source_second;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control domain: calibration and power-down sequencing

  adc_ctrl_pkg::cal_state_type state_q;
  logic [CNT_W-1:0] count_q;
  logic cal_request;

  assign cal_request = cal_pin && !cal_pin_prev_q && !pd_pin;

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state_q <= adc_ctrl_pkg::ST_POWER_WAIT;
      count_q <= '0;
    end else begin
      case (state_q)
        adc_ctrl_pkg::ST_POWER_WAIT: begin
          count_q <= '0;
          if (!pd_pin) begin
            state_q <= adc_ctrl_pkg::ST_DELAY;
          end
        end
        adc_ctrl_pkg::ST_DELAY: begin
          if (pd_pin) begin
            state_q <= adc_ctrl_pkg::ST_POWER_WAIT;
            count_q <= '0;
          end else if (count_q == CNT_W'(CAL_DELAY_CYCLES - 1)) begin
            state_q <= adc_ctrl_pkg::ST_CALIB;
            count_q <= '0;
          end else begin
            count_q <= count_q + CNT_W'(1);
          end
        end
        adc_ctrl_pkg::ST_CALIB: begin
          if (count_q == CNT_W'(CAL_CYCLES - 1)) begin
            state_q <= adc_ctrl_pkg::ST_RUN;
            count_q <= '0;
          end else begin
            count_q <= count_q + CNT_W'(1);
          end
        end
        adc_ctrl_pkg::ST_RUN: begin
          count_q <= '0;
          if (cal_request) begin
            state_q <= adc_ctrl_pkg::ST_CALIB;
          end
        end
        default: begin
          state_q <= adc_ctrl_pkg::ST_POWER_WAIT;
          count_q <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_power_saving <= 1'b0;
      o_second_channel_down <= 1'b0;
    end else begin
      o_power_saving <= pd_pin && state_q != adc_ctrl_pkg::ST_CALIB;
      o_second_channel_down <= qdown_pin;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_calibration_active <= 1'b0;
    end else begin
      o_calibration_active <= state_q == adc_ctrl_pkg::ST_CALIB;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_core_clock_run <= 1'b0;
    end else begin
      o_core_clock_run <= state_q == adc_ctrl_pkg::ST_RUN && !pd_pin;
    end
  end

  // pin DDR in normal mode only
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      mode_q <= adc_ctrl_pkg::MODE_RESET;
    end else begin
      mode_q[adc_ctrl_pkg::MD_DES] <= normal_mode ? des_pin == adc_ctrl_pkg::PIN_MID
                                                  : i_ext_des_enable;
      mode_q[adc_ctrl_pkg::MD_DDR] <= normal_mode ? edge_pin == adc_ctrl_pkg::PIN_MID
                                                  : i_ext_ddr_enable;
      mode_q[adc_ctrl_pkg::MD_RISE] <= normal_mode ? edge_pin == adc_ctrl_pkg::PIN_HIGH
                                                   : i_ext_edge_rising;
      mode_q[adc_ctrl_pkg::MD_PSAVE] <= pd_pin && state_q != adc_ctrl_pkg::ST_CALIB;
      mode_q[adc_ctrl_pkg::MD_QDOWN] <= qdown_pin;
      mode_q[adc_ctrl_pkg::MD_CAL] <= state_q == adc_ctrl_pkg::ST_CALIB;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_phase_trim_enable <= 1'b0;
    end else begin
      o_phase_trim_enable <= mode_q[adc_ctrl_pkg::MD_DES] && !mode_q[adc_ctrl_pkg::MD_CAL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: mode crossing and sample pipeline

  logic nrst_link;
  logic [adc_ctrl_pkg::MD_W-1:0] mode_l;
  logic cal_l;
  logic psave_l;
  logic phase_q;
  logic update;
  logic [7:0] first_hist_q [0:adc_ctrl_pkg::LAT_DELAYED-1];
  logic [7:0] second_hist_q [0:adc_ctrl_pkg::LAT_DELAYED-1];
  logic [adc_ctrl_pkg::LAT_DELAYED-1:0] over_hist_q;
  logic [4:0] warm_q;

  level_sync #(.WIDTH(1)) u_reset_sync (
    .i_clock(i_sample_clock_in),
    .i_level(i_nrst),
    .o_level(nrst_link)
  );

  // Mode bits are quasi-static; a change may take effect one edge apart per bit.
  level_sync #(.WIDTH(adc_ctrl_pkg::MD_W)) u_mode_sync (
    .i_clock(i_sample_clock_in),
    .i_level(mode_q),
    .o_level(mode_l)
  );

  assign cal_l = mode_l[adc_ctrl_pkg::MD_CAL];
  assign psave_l = mode_l[adc_ctrl_pkg::MD_PSAVE];

  always_ff @(posedge i_sample_clock_in) begin
    if (!nrst_link) begin
      phase_q <= 1'b0;
    end else if (!cal_l) begin
      phase_q <= ~phase_q;
    end
  end

  assign update = phase_q && !cal_l;

  // cores on opposite edges
  // The second core delivers its rising-edge sample; in interleave it leads the first
  // core's falling-edge sample of the same cycle by half a cycle.
  always_ff @(posedge i_sample_clock_in) begin
    first_hist_q[0] <= i_core_first_code;
    second_hist_q[0] <= i_core_second_code;
    for (int k = 1; k < adc_ctrl_pkg::LAT_DELAYED; k++) begin
      first_hist_q[k] <= first_hist_q[k-1];
      second_hist_q[k] <= second_hist_q[k-1];
    end
  end

  always_ff @(posedge i_sample_clock_in) begin
    over_hist_q <= {over_hist_q[adc_ctrl_pkg::LAT_DELAYED-2:0], i_core_overrange};
  end

  always_ff @(posedge i_sample_clock_in) begin
    if (!nrst_link) begin
      o_first_channel_direct_bus <= adc_ctrl_pkg::BUS_RESET;
      o_first_channel_delayed_bus <= adc_ctrl_pkg::BUS_RESET;
      o_second_channel_direct_bus <= adc_ctrl_pkg::BUS_RESET;
      o_second_channel_delayed_bus <= adc_ctrl_pkg::BUS_RESET;
    end else if (update) begin
      o_first_channel_direct_bus <= first_hist_q[adc_ctrl_pkg::DIRECT_TAP];
      o_first_channel_delayed_bus <= first_hist_q[adc_ctrl_pkg::DELAYED_TAP];
      o_second_channel_direct_bus <= second_hist_q[adc_ctrl_pkg::DIRECT_TAP];
      o_second_channel_delayed_bus <= second_hist_q[adc_ctrl_pkg::DELAYED_TAP];
    end
  end

  always_ff @(posedge i_sample_clock_in) begin
    if (!nrst_link || psave_l) begin
      o_overrange_output <= 1'b0;
    end else if (update) begin
      o_overrange_output <= over_hist_q[adc_ctrl_pkg::DIRECT_TAP];
    end
  end

  always_ff @(posedge i_sample_clock_in) begin
    if (!nrst_link || psave_l) begin
      o_forwarded_output_clock <= 1'b0;
    end else if (cal_l) begin
      o_forwarded_output_clock <= o_forwarded_output_clock;
    end else if (mode_l[adc_ctrl_pkg::MD_DDR]) begin
      o_forwarded_output_clock <= o_forwarded_output_clock ^ update;
    end else if (mode_l[adc_ctrl_pkg::MD_RISE]) begin
      o_forwarded_output_clock <= update;
    end else begin
      o_forwarded_output_clock <= !update;
    end
  end

  always_ff @(posedge i_sample_clock_in) begin
    if (!nrst_link) begin
      o_first_data_enable <= 1'b0;
      o_second_data_enable <= 1'b0;
    end else begin
      o_first_data_enable <= !psave_l;
      o_second_data_enable <= !psave_l && !mode_l[adc_ctrl_pkg::MD_QDOWN];
    end
  end

  // Counts edges since reset so that latency checks skip the unfilled pipeline.
  always_ff @(posedge i_sample_clock_in) begin
    if (!nrst_link) begin
      warm_q <= '0;
    end else if (warm_q != 5'h10) begin
      warm_q <= warm_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_range_code;
    @(posedge i_clock) disable iff (!i_nrst)
    range_pin == adc_ctrl_pkg::PIN_HIGH |=> o_fullscale_code == adc_ctrl_pkg::RANGE_CODE_HIGH;
  endproperty
  a_range_code: assert property (p_range_code) else $error("fixed range code wrong");

  property p_duty;
    @(posedge i_clock) disable iff (!i_nrst)
    normal_mode |=> o_duty_corrector_enable;
  endproperty
  a_duty: assert property (p_duty) else $error("duty corrector off in normal mode");

  property p_cal_finish;
    @(posedge i_clock) disable iff (!i_nrst)
    state_q == adc_ctrl_pkg::ST_CALIB ##1 state_q == adc_ctrl_pkg::ST_CALIB
      |-> !o_power_saving && o_calibration_active;
  endproperty
  a_cal_finish: assert property (p_cal_finish) else $error("power saving during cal");

  property p_cal_ignored;
    @(posedge i_clock) disable iff (!i_nrst)
    state_q == adc_ctrl_pkg::ST_RUN && pd_pin |=> state_q != adc_ctrl_pkg::ST_CALIB;
  endproperty
  a_cal_ignored: assert property (p_cal_ignored) else $error("cal started in power-down");

  property p_defer;
    @(posedge i_clock) disable iff (!i_nrst)
    state_q == adc_ctrl_pkg::ST_POWER_WAIT && pd_pin |=> o_power_saving;
  endproperty
  a_defer: assert property (p_defer) else $error("power-up cal not deferred");

  property p_sdr_rise;
    @(posedge i_sample_clock_in) disable iff (!nrst_link)
    update && !psave_l && !mode_l[adc_ctrl_pkg::MD_DDR] && mode_l[adc_ctrl_pkg::MD_RISE]
      |=> o_forwarded_output_clock;
  endproperty
  a_sdr_rise: assert property (p_sdr_rise) else $error("SDR rising clock wrong");

  property p_sdr_fall;
    @(posedge i_sample_clock_in) disable iff (!nrst_link)
    update && !psave_l && !mode_l[adc_ctrl_pkg::MD_DDR] && !mode_l[adc_ctrl_pkg::MD_RISE]
      |=> !o_forwarded_output_clock ##1 (o_forwarded_output_clock || $past(cal_l)
          || $past(psave_l) || $past(mode_l[adc_ctrl_pkg::MD_DDR])
          || $past(mode_l[adc_ctrl_pkg::MD_RISE]));
  endproperty
  a_sdr_fall: assert property (p_sdr_fall) else $error("SDR falling clock wrong");

  property p_ddr;
    @(posedge i_sample_clock_in) disable iff (!nrst_link)
    update && !psave_l && mode_l[adc_ctrl_pkg::MD_DDR]
      |=> o_forwarded_output_clock != $past(o_forwarded_output_clock);
  endproperty
  a_ddr: assert property (p_ddr) else $error("DDR clock did not toggle");

  property p_latency;
    @(posedge i_sample_clock_in) disable iff (!nrst_link)
    update && warm_q == 5'h10
      |=> o_first_channel_direct_bus == $past(i_core_first_code, 14)
          && o_second_channel_delayed_bus == $past(i_core_second_code, 15);
  endproperty
  a_latency: assert property (p_latency) else $error("bus latency wrong");

  property p_psave_pins;
    @(posedge i_sample_clock_in) disable iff (!nrst_link)
    psave_l |=> !o_first_data_enable && !o_forwarded_output_clock && !o_overrange_output;
  endproperty
  a_psave_pins: assert property (p_psave_pins) else $error("power-save pins wrong");

  property p_second_down;
    @(posedge i_sample_clock_in) disable iff (!nrst_link)
    mode_l[adc_ctrl_pkg::MD_QDOWN] && !psave_l |=> !o_second_data_enable && o_first_data_enable;
  endproperty
  a_second_down: assert property (p_second_down) else $error("second channel down wrong");

  property p_cal_stop;
    @(posedge i_sample_clock_in) disable iff (!nrst_link)
    cal_l && !psave_l |=> $stable(o_forwarded_output_clock) && $stable(o_first_channel_direct_bus);
  endproperty
  a_cal_stop: assert property (p_cal_stop) else $error("clock ran during cal");

  c_des: cover property (@(posedge i_sample_clock_in) disable iff (!nrst_link)
    mode_l[adc_ctrl_pkg::MD_DES] && update);
  c_ddr: cover property (@(posedge i_sample_clock_in) disable iff (!nrst_link)
    mode_l[adc_ctrl_pkg::MD_DDR] && update);
  c_cal_cmd: cover property (@(posedge i_clock) disable iff (!i_nrst)
    state_q == adc_ctrl_pkg::ST_RUN && cal_request);
  c_pd_in_cal: cover property (@(posedge i_clock) disable iff (!i_nrst)
    state_q == adc_ctrl_pkg::ST_CALIB && pd_pin);

endmodule

// [logic/level_sync.sv]
/*
  Two flip-flop synchroniser for slowly changing levels.
  Assumes each bit is stable long enough to be seen; bits of a vector may land one edge apart.
*/
module level_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock
  input wire logic i_clock,
  // Level from another domain
  input wire logic [WIDTH-1:0] i_level,
  // Synchronised level
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_width_check
    $error("level_sync needs WIDTH of at least 1");
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clock) begin
    meta_q <= i_level;
  end

  always_ff @(posedge i_clock) begin
    o_level <= meta_q;
  end

endmodule

// [sim/link_receiver.sv]
/*
  Receiving logic model for the forwarded link: counts forwarded clock edges and captures
  the first channel direct bus on each of them.
  Assumes the bench reads its counters and that an edge count restarts at each power-down.
*/
module link_receiver (
  // Link from the device
  input wire logic i_forwarded_output_clock,
  input wire logic [7:0] i_first_channel_direct_bus,
  input wire logic i_first_data_enable,
  // Observations
  output int o_edges,
  output logic [7:0] o_captured,
  output logic o_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_edges = 0;
    o_captured = 8'h00;
    o_valid = 1'b0;
  end
  always @(negedge i_first_data_enable) begin
    o_edges = 0;
    o_valid = 1'b0;
  end
  always @(i_forwarded_output_clock) begin
    o_edges = o_edges + 1;
    o_captured = i_first_channel_direct_bus;
    o_valid = i_first_data_enable && (o_edges > 4);
  end
endmodule

// [sim/test_adc_output_power_control.sv]
/*
  Bench for the converter control block: scenario tasks on pins, link and power.
  Assumes the receiver model beside the link and shortened calibration counts.
*/
module test_adc_output_power_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL_N = 20;
  logic clk = 1'b0;
  logic sclk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] range = adc_ctrl_pkg::PIN_HIGH;
  logic [1:0] oedge = adc_ctrl_pkg::PIN_HIGH;
  logic [1:0] des = adc_ctrl_pkg::PIN_LOW;
  logic [1:0] qdown = adc_ctrl_pkg::PIN_LOW;
  logic pd = 1'b1;
  logic cal = 1'b0;
  logic ddr = 1'b0;
  logic rise = 1'b1;
  logic duty_off = 1'b1;
  logic dsel = 1'b1;
  logic [7:0] scnt = 8'h00;
  logic [8:0] fsc;
  logic dce, cact, psave, qd, crun, trim, dsrc, fclk, ovr, fen, sen, vld;
  logic [7:0] fdir, fdel, sdir, sdel, cap;
  int edges;
  int n;
  int errors = 0;
  int comparisons = 0;
  initial forever #5 clk = ~clk;
  initial begin
    #3;
    forever #24 sclk = ~sclk;
  end
  // Codes count so that each bus value tells when it was sampled.
  always @(negedge sclk) scnt <= scnt + 8'h01;
  adc_output_power_control #(.CAL_DELAY_CYCLES(8), .CAL_CYCLES(CAL_N)) DUT (
    .i_clock(clk), .i_nrst(nrst), .i_sample_clock_in(sclk), .i_range_select_pin(range),
    .i_output_edge_select(oedge), .i_des_select_pin(des), .i_second_channel_power_down(qdown),
    .i_full_power_down(pd), .i_calibration_command(cal), .i_ext_fullscale_code(9'h0a5),
    .i_ext_duty_corrector_off(duty_off), .i_ext_ddr_enable(ddr), .i_ext_edge_rising(rise),
    .i_ext_des_enable(dsel), .i_ext_des_source_second(dsel), .i_core_first_code(scnt),
    .i_core_second_code(scnt ^ 8'h80), .i_core_overrange(scnt[0]), .o_fullscale_code(fsc),
    .o_duty_corrector_enable(dce), .o_calibration_active(cact), .o_power_saving(psave),
    .o_second_channel_down(qd), .o_core_clock_run(crun), .o_phase_trim_enable(trim),
    .o_des_source_second(dsrc), .o_forwarded_output_clock(fclk), .o_overrange_output(ovr),
    .o_first_channel_direct_bus(fdir), .o_first_channel_delayed_bus(fdel),
    .o_second_channel_direct_bus(sdir), .o_second_channel_delayed_bus(sdel),
    .o_first_data_enable(fen), .o_second_data_enable(sen));
  link_receiver rx (.i_forwarded_output_clock(fclk), .i_first_channel_direct_bus(fdir),
    .i_first_data_enable(fen), .o_edges(edges), .o_captured(cap), .o_valid(vld));
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic stop_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Waits for a calibration, checks the frozen link inside it and returns its length.
  task automatic cal_run(output int len);
    int t;
    int e;
    t = 0;
    len = 0;
    e = 0;
    while (cact !== 1'b1 && t < 300) begin
      tick(1);
      t++;
    end
    while (cact === 1'b1 && len < 300) begin
      tick(1);
      len++;
      if (len == 12) begin
        e = edges;
        check("core clock run", 9'h0, crun);
      end
    end
    check("edges in cal", e[8:0], edges[8:0]);
  endtask
  task automatic cal_pulse;
    cal = 1'b1;
    tick(4);
    cal = 1'b0;
  endtask
  // Kind 0 expects data on the rising clock edge, 1 on the falling, 2 on both.
  task automatic test_link(input logic [1:0] pin, input int kind);
    logic prev;
    logic expc;
    logic [7:0] last;
    int u;
    oedge = pin;
    tick(100);
    prev = fclk;
    last = fdir;
    u = 0;
    repeat (40) begin
      @(posedge sclk);
      #1;
      if (fdir !== last) begin
        u++;
        expc = (kind == 2) ? ~prev : (kind == 0);
        check("first direct", 8'(scnt - 8'h0d), fdir);
        check("first delayed", 8'(scnt - 8'h0e), fdel);
        check("overrange", {8'h00, ~scnt[0]}, ovr);
        check("fwd clock", expc, fclk);
        prev = fclk;
        last = fdir;
      end
    end
    check("updates", 9'h1, u > 15);
    check("rx valid", 9'h1, vld);
    if (kind == 0) begin
      @(negedge fclk);
      #1;
      check("rx capture", 8'(scnt - 8'h0e), cap);
    end
    tick(1);
    $display("test link kind %0d done", kind);
  endtask
  task automatic test_range;
    check("core run", 9'h1, crun);
    range = adc_ctrl_pkg::PIN_LOW;
    tick(6);
    check("fullscale low", adc_ctrl_pkg::RANGE_CODE_LOW, fsc);
    check("duty normal", 9'h1, dce);
    range = adc_ctrl_pkg::PIN_MID;
    tick(6);
    check("fullscale ext", 9'h0a5, fsc);
    check("duty ext off", 9'h0, dce);
    check("des source ext", 9'h1, dsrc);
    check("ext interleave trim", 9'h1, trim);
    range = adc_ctrl_pkg::PIN_HIGH;
    tick(6);
    check("fullscale high", adc_ctrl_pkg::RANGE_CODE_HIGH, fsc);
    $display("test range done");
  endtask
  task automatic test_des;
    int t;
    logic [7:0] last;
    cal_pulse(); // calibrate before interleave
    cal_run(n);
    des = adc_ctrl_pkg::PIN_MID;
    tick(100);
    check("phase trim", 9'h1, trim);
    check("des source", 9'h0, dsrc);
    t = 0;
    last = sdir;
    while (sdir === last && t < 4) begin
      @(posedge sclk);
      #1;
      t++;
    end
    check("second direct", 8'((scnt - 8'h0d) ^ 8'h80), sdir);
    check("second delayed", 8'((scnt - 8'h0e) ^ 8'h80), sdel);
    tick(1);
    des = adc_ctrl_pkg::PIN_LOW;
    tick(100);
    check("phase trim off", 9'h0, trim);
    $display("test des done");
  endtask
  task automatic test_power;
    int e;
    qdown = adc_ctrl_pkg::PIN_HIGH;
    tick(30);
    check("second enable", 9'h0, sen);
    check("first enable", 9'h1, fen);
    check("second down flag", 9'h1, qd);
    qdown = adc_ctrl_pkg::PIN_LOW;
    cal_pulse(); // recalibrate before second use
    cal_run(n);
    pd = 1'b1;
    tick(30);
    check("power saving", 9'h1, psave);
    check("data enable", 9'h0, fen);
    check("rx invalid", 9'h0, vld);
    e = edges;
    tick(50);
    check("clock low", 9'h0, fclk);
    check("overrange low", 9'h0, ovr);
    check("pd edges", e[8:0], edges[8:0]);
    cal_pulse();
    tick(40);
    check("cal ignored", 9'h0, cact);
    pd = 1'b0;
    tick(40);
    check("no late cal", 9'h0, cact);
    cal = 1'b1;
    while (cact !== 1'b1 && e < 400) begin
      tick(1);
      e++;
    end
    cal = 1'b0;
    pd = 1'b1;
    tick(5);
    check("pd waits for cal", 9'h1, cact & ~psave);
    tick(CAL_N + 10);
    check("pd after cal", 9'h1, psave);
    pd = 1'b0;
    tick(60);
    check("rx valid again", 9'h1, vld);
    $display("test power done");
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    errors++;
    stop_test();
  end
  initial begin
    tick(12);
    check("reset fullscale", adc_ctrl_pkg::RANGE_CODE_DEFAULT, fsc);
    check("reset duty", 9'h1, dce);
    nrst = 1'b1;
    tick(40);
    check("no cal in pd", 9'h0, cact);
    check("pd at power-up", 9'h1, psave);
    pd = 1'b0;
    cal_run(n);
    check("cal length", CAL_N, n);
    test_range();
    test_link(adc_ctrl_pkg::PIN_HIGH, 0);
    test_link(adc_ctrl_pkg::PIN_LOW, 1);
    test_link(adc_ctrl_pkg::PIN_MID, 2);
    range = adc_ctrl_pkg::PIN_MID;
    test_link(adc_ctrl_pkg::PIN_MID, 0);
    range = adc_ctrl_pkg::PIN_HIGH;
    test_des();
    test_power();
    stop_test();
  end
endmodule
